// ===== core/sdw_write_port.sv
/*
 * write-only three wire serial port of a single channel DAC, with the
 * converter register held in the system clock domain.
 * assumes the host keeps link_sclk still or running only as the three wire
 * timing allows, and that sel_n and din change away from falling edges.
 */
`timescale 1ns/10ps

module sdw_write_port
	import sdw_pkg::*;
#(
	parameter sdw_res_e RES = SDW_RES_16
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   link_sclk,
	input  wire logic                   sel_n,
	input  wire logic                   din,
	output logic      [`SDW_CODE_W-1:0] dac_code,
	output logic      [`SDW_WORD_W-1:0] dac_word,
	output logic                        dac_load,
	output logic                        frame_active,
	output logic                        frame_abort,
	output logic      [`SDW_STAT_W-1:0] update_count,
	output logic      [`SDW_STAT_W-1:0] abort_count
);

	// variant dependent sizes
	localparam int SHIFT_W   = (RES == SDW_RES_16) ? `SDW_SHIFT_W_WIDE : `SDW_SHIFT_W_NARROW;
	localparam int FRAME_LEN = (RES == SDW_RES_16) ? `SDW_FRAME_LEN_WIDE : `SDW_FRAME_LEN_NARROW;
	localparam int CODE_BITS = (RES == SDW_RES_16) ? 16 : ((RES == SDW_RES_14) ? 14 : 12);
	localparam logic [`SDW_CNT_W-1:0] LAST_BIT = `SDW_CNT_W'(FRAME_LEN - 1);
	localparam logic [`SDW_CNT_W-1:0] DONE_CNT = `SDW_CNT_W'(FRAME_LEN);
	localparam logic [1:0] SETTLE_LAST = 2'(`SDW_SETTLE_CYCLES - 1);

	// keeps the code bits of a frame word, unsigned and zero-extended
	function automatic logic [`SDW_CODE_W-1:0] code_of(input logic [`SDW_WORD_W-1:0] w);
		logic [`SDW_CODE_W-1:0] mask;
		mask    = `SDW_CODE_W'((32'h1 << CODE_BITS) - 32'h1);
		code_of = w[`SDW_CODE_W-1:0] & mask;
	endfunction

	// saturating increment for the statistics
	function automatic logic [`SDW_STAT_W-1:0] bump(input logic [`SDW_STAT_W-1:0] v);
		bump = (v == {`SDW_STAT_W{1'b1}}) ? v : v + `SDW_STAT_W'(1);
	endfunction

	// ------------------------------------------------------------------
	// link domain, clocked by the host's serial clock
	// ------------------------------------------------------------------

	logic [SHIFT_W-1:0]     shift;
	logic [`SDW_CNT_W-1:0]  bit_cnt;
	logic [`SDW_WORD_W-1:0] hold_word;
	logic                   load_toggle;
	logic [SHIFT_W-1:0]     next_shift;

	// next shift value, newest bit into the low end
	// one bit per edge
	assign next_shift = {shift[SHIFT_W-2:0], din};

	// shift register and counter held clear while select is high
	// async clear is needed: the serial clock may be still when select rises
	// enable only in frame
	always_ff @(negedge link_sclk or posedge sel_n) begin
		if (sel_n) begin
			shift   <= '0;
			bit_cnt <= '0;
		end else if (bit_cnt != DONE_CNT) begin
			shift   <= next_shift;
			bit_cnt <= bit_cnt + `SDW_CNT_W'(1);
		end
	end

	// completed word is held for the system domain and flagged by a toggle
	// extra clocks past the last bit are ignored until select goes high
	// wide variant loads after 24th edge
	// narrow variants load after 16th edge
	always_ff @(negedge link_sclk or posedge rst) begin
		if (rst) begin
			hold_word   <= `SDW_WORD_RESET;
			load_toggle <= 1'b0;
		end else if (!sel_n && bit_cnt == LAST_BIT) begin
			hold_word   <= `SDW_WORD_W'(next_shift);
			load_toggle <= ~load_toggle;
		end
	end

	// ------------------------------------------------------------------
	// system domain
	// ------------------------------------------------------------------

	logic load_pulse;
	logic sel_meta;
	logic sel_stable;
	logic in_frame;

	// word arrival crosses as a toggle; hold_word is steady long before
	// only whole frames toggle
	sdw_event_sync u_load_sync (
		.clock  (clock),
		.rst    (rst),
		.toggle (load_toggle),
		.pulse  (load_pulse)
	);

	// frame select level into the system domain
	always_ff @(posedge clock) begin
		if (rst) begin
			sel_meta   <= 1'b1;
			sel_stable <= 1'b1;
		end else begin
			sel_meta   <= sel_n;
			sel_stable <= sel_meta;
		end
	end

	assign in_frame = ~sel_stable;

	// converter register, loaded only by a completed frame
	// the word is taken from hold_word, stable since its toggle
	// straight binary code
	always_ff @(posedge clock) begin
		if (rst) begin
			dac_code <= `SDW_CODE_RESET;
			dac_word <= `SDW_WORD_RESET;
		end else if (load_pulse) begin
			dac_code <= code_of(hold_word);
			dac_word <= hold_word;
		end
	end

	// one-cycle load strobe from a flop
	always_ff @(posedge clock) begin
		if (rst) begin
			dac_load <= 1'b0;
		end else begin
			dac_load <= load_pulse;
		end
	end

	// ------------------------------------------------------------------
	// frame tracking: tells an aborted frame from a completed one
	// ------------------------------------------------------------------

	sdw_state_e state;
	sdw_state_e next_state;
	logic       seen_load;
	logic [1:0] settle_cnt;

	// the load toggle and the select rise may reach this side in either
	// order, so the verdict waits out the settle window
	always_comb begin
		next_state = state;
		case (state)
			SDW_ST_IDLE: begin
				if (in_frame) begin
					next_state = SDW_ST_FRAME;
				end
			end
			SDW_ST_FRAME: begin
				if (!in_frame) begin
					next_state = SDW_ST_SETTLE;
				end
			end
			SDW_ST_SETTLE: begin
				if (settle_cnt == SETTLE_LAST) begin
					next_state = SDW_ST_IDLE;
				end
			end
			default: begin
				next_state = SDW_ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= SDW_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// settle window counter
	always_ff @(posedge clock) begin
		if (rst) begin
			settle_cnt <= 2'h0;
		end else if (state == SDW_ST_SETTLE) begin
			settle_cnt <= settle_cnt + 2'h1;
		end else begin
			settle_cnt <= 2'h0;
		end
	end

	// load seen in this frame; a load wins over the clear at frame start
	always_ff @(posedge clock) begin
		if (rst) begin
			seen_load <= 1'b0;
		end else if (load_pulse) begin
			seen_load <= 1'b1;
		end else if (state == SDW_ST_IDLE && in_frame) begin
			seen_load <= 1'b0;
		end
	end

	// abort strobe: frame ended without a load
	// rising select before last edge
	always_ff @(posedge clock) begin
		if (rst) begin
			frame_abort <= 1'b0;
		end else begin
			frame_abort <= (state == SDW_ST_SETTLE) && (settle_cnt == SETTLE_LAST) && !seen_load && !load_pulse;
		end
	end

	// frame active level from a flop
	always_ff @(posedge clock) begin
		if (rst) begin
			frame_active <= 1'b0;
		end else begin
			frame_active <= in_frame;
		end
	end

	// statistics, saturating so a long run never wraps to a false zero
	always_ff @(posedge clock) begin
		if (rst) begin
			update_count <= '0;
		end else if (load_pulse) begin
			update_count <= bump(update_count);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			abort_count <= '0;
		end else if (frame_abort) begin
			abort_count <= bump(abort_count);
		end
	end

endmodule

// ===== include/sdw_defines.svh
/*
 * constants for the serial DAC write port: frame lengths, widths,
 * reset values and timing counts.
 * assumes it is included by bare name before the package is compiled.
 */
`ifndef SDW_DEFINES_SVH
`define SDW_DEFINES_SVH

// frame lengths in serial clock falling edges
`define SDW_FRAME_LEN_WIDE   24
`define SDW_FRAME_LEN_NARROW 16

// shift register widths per variant
`define SDW_SHIFT_W_WIDE     24
`define SDW_SHIFT_W_NARROW   16

// widest shift word carried across the crossing
`define SDW_WORD_W           24
`define SDW_CODE_W           16
`define SDW_CNT_W            5

// reset values
`define SDW_CODE_RESET       16'h0000
`define SDW_WORD_RESET       24'h000000

// system clock period and least frame select high time, in ns
`define SDW_CLK_PERIOD_NS    25
`define SDW_T_SYNC_HIGH_NS   50
// least time rounds up, never below one cycle
`define SDW_SETTLE_CYCLES    ((`SDW_T_SYNC_HIGH_NS + `SDW_CLK_PERIOD_NS - 1) / `SDW_CLK_PERIOD_NS)

// width of the frame statistics counters
`define SDW_STAT_W           16

`endif

// ===== include/sdw_pkg.sv
/*
 * types for the serial DAC write port.
 * assumes sdw_defines.svh is reachable on the include path.
 */
`include "sdw_defines.svh"

package sdw_pkg;

	// resolution variant of the converter
	typedef enum logic [1:0] {
		SDW_RES_12,
		SDW_RES_14,
		SDW_RES_16
	} sdw_res_e;

	// frame tracking in the system domain
	typedef enum logic [1:0] {
		SDW_ST_IDLE,
		SDW_ST_FRAME,
		SDW_ST_SETTLE
	} sdw_state_e;

	// select and data wires of the three wire link as seen at the pins
	typedef struct packed {
		logic sel_n;
		logic din;
	} sdw_link_s;

	// converter output word and its companions
	typedef struct packed {
		logic [`SDW_CODE_W-1:0] code;
		logic [`SDW_WORD_W-1:0] word;
	} sdw_dac_s;

	// frame statistics
	typedef struct packed {
		logic [`SDW_STAT_W-1:0] updates;
		logic [`SDW_STAT_W-1:0] aborts;
	} sdw_stat_s;

endpackage

// ===== core/sdw_event_sync.sv
/*
 * toggle synchroniser: turns a toggle from the link domain into a
 * one-cycle pulse on the system clock.
 * assumes toggles are spaced by far more than three system clocks.
 */
`timescale 1ns/10ps

module sdw_event_sync
	import sdw_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic toggle,
	output logic      pulse
);

	logic meta;
	logic stable;
	logic last;

	// two flops, then edge detect on the second only
	always_ff @(posedge clock) begin
		if (rst) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			last   <= 1'b0;
		end else begin
			meta   <= toggle;
			stable <= meta;
			last   <= stable;
		end
	end

	// edge-detect output may be combinational
	assign pulse = stable ^ last;

endmodule

// ===== sim/sdw_write_port_properties.sv
/*
 * checker for the serial DAC write port, system clock domain.
 * assumes it is bound to every sdw_write_port instance.
 */
`include "sdw_defines.svh"
`timescale 1ns/10ps

module sdw_write_port_properties
	import sdw_pkg::*;
#(
	parameter sdw_res_e RES = SDW_RES_16
) (
	input wire logic                   clock,
	input wire logic                   rst,
	input wire logic                   sel_n,
	input wire logic [`SDW_CODE_W-1:0] dac_code,
	input wire logic [`SDW_WORD_W-1:0] dac_word,
	input wire logic                   dac_load,
	input wire logic                   frame_active,
	input wire logic                   frame_abort,
	input wire logic [`SDW_STAT_W-1:0] update_count
);
	// code and word widths of this variant
	localparam int CB = RES == SDW_RES_12 ? 12 : RES == SDW_RES_14 ? 14 : 16;
	localparam int WB = RES == SDW_RES_16 ? 24 : 16;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// code, word, count and load strobe all move on the same system edge
	property p_code_load; $changed(dac_code) |-> dac_load; endproperty
	a_code_load: assert property (p_code_load) else $error("code moved without load");
	property p_word_load; $changed(dac_word) |-> dac_load; endproperty
	a_word_load: assert property (p_word_load) else $error("word moved without load");
	property p_count_load; $changed(update_count) |-> dac_load; endproperty
	a_count_load: assert property (p_count_load) else $error("count moved without load");
	property p_load_pulse; dac_load |-> !frame_abort ##1 !dac_load; endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("load not a lone pulse");
	property p_abort_keeps; frame_abort |-> !frame_active && $stable(dac_code); endproperty
	a_abort_keeps: assert property (p_abort_keeps) else $error("abort disturbed code");
	property p_code_width; (dac_code >> CB) == 0; endproperty
	a_code_width: assert property (p_code_width) else $error("code above resolution");
	property p_word_width; (dac_word >> WB) == 0; endproperty
	a_word_width: assert property (p_word_width) else $error("word above shift width");
	property p_idle; sel_n [*5] |-> !frame_active; endproperty
	a_idle: assert property (p_idle) else $error("frame active while deselected");
	property p_busy; !sel_n [*5] |-> frame_active; endproperty
	a_busy: assert property (p_busy) else $error("frame idle while selected");
endmodule

// ===== sim/sdw_host_model.sv
/*
 * host side of the three wire link: select, serial clock, data.
 * assumes the bench calls send once at a time; clock parks high.
 */
`timescale 1ns/10ps

module sdw_host_model (
	output logic sclk,
	output logic sel_n,
	output logic din
);
	// idle levels, clock still outside frames
	initial begin
		sclk = 1'b1;
		sel_n = 1'b1;
		din = 1'b0;
	end

	// one frame of n falls, optional stall after bit 12
	task automatic send(input logic [23:0] w, input int n, input int gap);
		int i;
		sel_n = 1'b0;
		#20;
		for (i = 0; i < n; i++) begin
			din = w[23 - i % 24];
			#40 sclk = 1'b0;
			#40 sclk = 1'b1;
			if (i == 11) #(gap);
		end
		#10 sel_n = 1'b1;
		din = ~din; // released line, not the last value
		#300;
	endtask
endmodule

// ===== sim/test_serial_dac_write_port.sv
/*
 * bench for the serial DAC write port, all three variants side by side.
 * assumes the host model paces the link; bind at the foot.
 */
`timescale 1ns/10ps

module test_serial_dac_write_port
	import sdw_pkg::*;
	;
	logic        clock, rst, sclk, sel_n, din;
	logic [15:0] code [3];
	logic [23:0] word [3];
	logic        load [3];
	logic [15:0] upd [3];
	logic [15:0] abt [3];
	logic [23:0] ecode [3], eword [3], w;
	int          eupd [3], eabt [3], nload [3];
	int          error_cnt, tests_run, seed, k, n, g;
	int          tab [6] = '{24, 24, 16, 10, 0, 30};

	// system clock, 25 ns
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	sdw_host_model host (.sclk(sclk), .sel_n(sel_n), .din(din));

	// one instance per resolution, sharing the link
	for (genvar j = 0; j < 3; j++) begin : v
		sdw_write_port #(.RES(sdw_res_e'(j))) uut (
			.clock(clock), .rst(rst), .link_sclk(sclk), .sel_n(sel_n), .din(din),
			.dac_code(code[j]), .dac_word(word[j]), .dac_load(load[j]), .frame_active(),
			.frame_abort(), .update_count(upd[j]), .abort_count(abt[j]));
		// count load pulses independently of the counters
		always @(posedge clock) begin
			if (load[j] === 1'b1) nload[j]++;
		end
	end

	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// short frames abort, full ones load the leading bits
	function automatic void expect_frame(input int j, input logic [23:0] w, input int n);
		int fl;
		fl = j == 2 ? 24 : 16;
		if (n < fl) eabt[j]++;
		else begin
			eupd[j]++;
			eword[j] = w >> (24 - fl);
			ecode[j] = eword[j] & ((24'h1 << (12 + 2 * j)) - 24'h1);
		end
	endfunction

	task automatic finish_test;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// corner frames first, then random words and lengths
	initial begin
		seed = 32'hb040;
		rst <= 1'b1;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		for (k = -1; k < 40; k++) begin
			if (k >= 0) begin
				w = k == 0 ? 24'hffffff : k == 1 ? 24'h0 : 24'($random(seed));
				n = k < 6 ? tab[k] : (k % 5 == 4 ? 16 + $unsigned($random(seed)) % 9 : 24);
				host.send(w, n, (k % 3) * 200);
				for (g = 0; g < 3; g++) expect_frame(g, w, n);
				repeat (4) @(posedge clock);
			end else begin
				ecode = '{default: 24'h0};
				eword = '{default: 24'h0};
			end
			for (g = 0; g < 3; g++) begin
				check("code", ecode[g], 24'(code[g]));
				check("word", eword[g], word[g]);
				check("updates", 24'(eupd[g]), 24'(upd[g]));
				check("aborts", 24'(eabt[g]), 24'(abt[g]));
				check("pulses", 24'(eupd[g]), 24'(nload[g]));
			end
		end
		finish_test();
	end

	// hang guard, well beyond the frame sequence
	initial begin
		#(20000 * 25);
		error_cnt++;
		finish_test();
	end
endmodule

bind sdw_write_port sdw_write_port_properties #(.RES(RES)) chk (
	.clock(clock), .rst(rst), .sel_n(sel_n), .dac_code(dac_code), .dac_word(dac_word),
	.dac_load(dac_load), .frame_active(frame_active), .frame_abort(frame_abort),
	.update_count(update_count));
